// >>> hdl/psa_unit.sv
// Execute-stage datapath for packed absolute value, packed adds and address adds.
`timescale 1ns/1ps
`default_nettype none
`include "psa_regs.svh"

// Contract
// (RL1) Each signed halfword gets its absolute value; most negative saturates to maximum.
// (RL2) Packed absolute value never touches the saturation flag.
// (RL3) Dual halfword add forms two signed 16-bit sums in matching lanes.
// (RL4) No carry passes from the low halfword sum into the high one.
// (RL5) Dual halfword add runs on shift, logic and data-address units.
// (RL6) Quad byte add sums four independent 8-bit lanes into matching bytes.
// (RL7) Quad byte lane results wrap modulo 256, never saturate.
// (RL8) No carry crosses between any two byte lanes.
// (RL9) Doubleword address add: first operand shifted left three, plus second operand.
// (RL10) Linear by default; registers 4 to 7 either side follow addressing mode.
// (RL11) PC-relative add: signed 7-bit constant shifted left two plus packet base.
// (RL12) PC-relative add inserts its 3-bit count of no-operation cycles afterwards.
// (RL13) Instruction stream issues at most one PC-relative add per cycle.
// (RL14) Instruction stream never pairs PC-relative add with a taken relative branch.
// (RL15) Circular mode changes only result bits N to 0; upper bits keep base.
// (RL16) Circular block size is a byte count, never scaled by data size.
// (RL17) A failed predicate leaves the destination unchanged like a no-operation.
// (RL18) Sources read and destination written in one stage, zero delay slots.
module psa_unit
   import psa_pkg::*;
(
   input  wire logic         CLK,
   input  wire logic         NRST,
   input  wire logic         CE,
   input  wire logic         ISSUE,
   input  wire psa_op_type   OP,
   input  wire psa_unit_type UNIT,
   input  wire logic         COND_PASS,
   input  wire logic [31:0]  SRC1,
   input  wire logic [31:0]  SRC2,
   input  wire logic [4:0]   BASE_IDX,
   input  wire logic         BASE_SIDE_B,
   input  wire logic [31:0]  ADDRESSING_MODE_REGISTER,
   input  wire logic [31:0]  FETCH_BASE,
   input  wire logic [6:0]   CONST7,
   input  wire logic [2:0]   NOP_COUNT,
   output logic      [31:0]  RESULT,
   output logic              RESULT_WE,
   output logic              BUSY,
   output logic              ILLEGAL,
   output logic              SAT_SET
);

   logic [31:0]   result_ff;
   logic [31:0]   nxt_result;
   logic          we_ff;
   logic          nxt_we;
   logic          illegal_ff;
   logic          nxt_illegal;
   logic          sat_ff;
   logic          nxt_sat;
   psa_state_type st_ff;
   psa_state_type nxt_st;
   logic [2:0]    nop_cnt_ff;
   logic [2:0]    nxt_nop_cnt;
   logic          busy_ff;
   logic          nxt_busy;

   logic          accept;
   logic          legal;
   logic          exec;
   logic [31:0]   abs_val;
   logic [31:0]   dual_halfword_add_val;
   logic [31:0]   quad_byte_add_val;
   logic [31:0]   lin_val;
   logic [31:0]   adr_val;
   logic [31:0]   pcrel_val;
   logic [31:0]   op_val;
   logic [2:0]    mode_sel;
   logic [1:0]    mode;
   logic [4:0]    bk;
   logic          circ_reg;
   logic          circ;
   logic [63:0]   mask64;
   logic [31:0]   circ_mask;

   // Issues arriving during inserted no-operation cycles are not taken.
   assign accept = ISSUE && (st_ff == ST_RUN); // RL12

   always_comb begin
      case (OP)
         OP_HALF_ABS:  legal = (UNIT == UNIT_LOGIC);
         OP_HALF_ADD:  legal = 1'b1; // RL5
         OP_BYTE_ADD:  legal = (UNIT == UNIT_LOGIC);
         OP_DWADR_ADD: legal = (UNIT == UNIT_DADDR);
         OP_PCREL_ADD: legal = (UNIT == UNIT_SHIFT);
         default:      legal = 1'b0;
      endcase
   end

   assign exec = accept && legal && COND_PASS; // RL17

   for (genvar h = 0; h < 2; h++) begin : g_half
      logic [15:0] x;
      assign x = SRC2[`PSA_HALF_W*h +: `PSA_HALF_W];
      assign abs_val[`PSA_HALF_W*h +: `PSA_HALF_W] =
         (x == `PSA_HALF_MIN) ? `PSA_HALF_MAX :
         x[15] ? (~x + `PSA_HALF_ONE) : x; // RL1
      psa_lane_add #(.W(`PSA_HALF_W)) u_add ( // RL3 RL4
         .a   (SRC1[`PSA_HALF_W*h +: `PSA_HALF_W]),
         .b   (SRC2[`PSA_HALF_W*h +: `PSA_HALF_W]),
         .sum (dual_halfword_add_val[`PSA_HALF_W*h +: `PSA_HALF_W])
      );
   end

   for (genvar b = 0; b < 4; b++) begin : g_byte
      psa_lane_add #(.W(`PSA_BYTE_W)) u_add ( // RL6 RL7 RL8
         .a   (SRC1[`PSA_BYTE_W*b +: `PSA_BYTE_W]),
         .b   (SRC2[`PSA_BYTE_W*b +: `PSA_BYTE_W]),
         .sum (quad_byte_add_val[`PSA_BYTE_W*b +: `PSA_BYTE_W])
      );
   end

   // Circular mode comes from the two-bit field of the base register.
   assign mode_sel  = {BASE_SIDE_B, BASE_IDX[1:0]};
   assign mode      = ADDRESSING_MODE_REGISTER[{mode_sel, 1'b0} +: `PSA_MODE_W];
   assign circ_reg  = (BASE_IDX >= `PSA_CIRC_IDX_LO) && (BASE_IDX <= `PSA_CIRC_IDX_HI); // RL10
   assign circ      = circ_reg && ((mode == `PSA_MODE_CIRC0) || (mode == `PSA_MODE_CIRC1)); // RL10
   assign bk        = (mode == `PSA_MODE_CIRC0) ? ADDRESSING_MODE_REGISTER[`PSA_AMR_BK0_LSB +: `PSA_BK_W]
                                                : ADDRESSING_MODE_REGISTER[`PSA_AMR_BK1_LSB +: `PSA_BK_W];
   // The block field is used as a byte exponent directly, with no data-size scaling.
   assign mask64    = ~(`PSA_ONES64 << ({1'b0, bk} + `PSA_SHAMT_ONE)); // RL16
   assign circ_mask = mask64[31:0];
   assign lin_val   = SRC2 + (SRC1 << `PSA_DW_SHIFT); // RL9
   assign adr_val   = circ ? ((SRC2 & ~circ_mask) | (lin_val & circ_mask)) : lin_val; // RL15
   assign pcrel_val = FETCH_BASE + (32'($signed(CONST7)) << `PSA_PCREL_SHIFT); // RL11

   always_comb begin
      case (OP)
         OP_HALF_ABS:  op_val = abs_val;
         OP_HALF_ADD:  op_val = dual_halfword_add_val;
         OP_BYTE_ADD:  op_val = quad_byte_add_val;
         OP_DWADR_ADD: op_val = adr_val;
         OP_PCREL_ADD: op_val = pcrel_val;
         default:      op_val = `PSA_ZERO32;
      endcase
   end

   // Result path: written at the end of the single execute stage.
   always_comb begin
      nxt_result  = exec ? op_val : result_ff; // RL17 RL18
      nxt_we      = exec; // RL18
      nxt_illegal = accept && !legal;
      nxt_sat     = 1'b0; // RL2
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         result_ff  <= `PSA_ZERO32;
         we_ff      <= 1'b0;
         illegal_ff <= 1'b0;
         sat_ff     <= 1'b0;
      end else if (CE) begin
         result_ff  <= nxt_result;
         we_ff      <= nxt_we;
         illegal_ff <= nxt_illegal;
         sat_ff     <= nxt_sat;
      end
   end

   // No-operation insertion after a PC-relative add, predicated or not.
   always_comb begin
      nxt_st      = st_ff;
      nxt_nop_cnt = nop_cnt_ff;
      case (st_ff)
         ST_RUN: begin
            if (accept && legal && (OP == OP_PCREL_ADD) && (NOP_COUNT != `PSA_NOP_ZERO)) begin
               nxt_st      = ST_NOP; // RL12
               nxt_nop_cnt = NOP_COUNT;
            end
         end
         ST_NOP: begin
            nxt_nop_cnt = nop_cnt_ff - `PSA_NOP_ONE; // RL12
            if (nop_cnt_ff == `PSA_NOP_ONE) begin
               nxt_st = ST_RUN;
            end
         end
         default: begin
            nxt_st      = ST_RUN;
            nxt_nop_cnt = `PSA_NOP_ZERO;
         end
      endcase
      nxt_busy = (nxt_st == ST_NOP);
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         st_ff      <= ST_RUN;
         nop_cnt_ff <= `PSA_NOP_ZERO;
         busy_ff    <= 1'b0;
      end else if (CE) begin
         st_ff      <= nxt_st;
         nop_cnt_ff <= nxt_nop_cnt;
         busy_ff    <= nxt_busy;
      end
   end

   assign RESULT    = result_ff;
   assign RESULT_WE = we_ff;
   assign BUSY      = busy_ff;
   assign ILLEGAL   = illegal_ff;
   assign SAT_SET   = sat_ff;

   // Helper values sampled by the checks below.
   logic [15:0] chk_hi;
   logic [7:0]  chk_b3;
   logic [31:0] chk_lin;
   assign chk_hi  = SRC1[31:16] + SRC2[31:16];
   assign chk_b3  = SRC1[31:24] + SRC2[31:24];
   assign chk_lin = SRC2 + {SRC1[28:0], 3'h0};

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!NRST);

   a_abs_half_sat: assert property (CE && exec && OP == OP_HALF_ABS && SRC2[31:16] == 16'h8000 // RL1
      |=> RESULT[31:16] == 16'h7fff) else $error("halfword abs did not saturate");
   a_sat_untouched: assert property (!SAT_SET) // RL2
      else $error("saturation flag was raised");
   a_dual_halfword_add_high_lane: assert property (CE && exec && OP == OP_HALF_ADD // RL4
      |=> RESULT[31:16] == $past(chk_hi)) else $error("high halfword sum wrong");
   a_dual_halfword_add_any_unit: assert property (CE && accept && OP == OP_HALF_ADD && COND_PASS // RL5
      |=> RESULT_WE && !ILLEGAL) else $error("dual halfword add refused on a unit");
   a_quad_byte_add_top_byte: assert property (CE && exec && OP == OP_BYTE_ADD // RL8
      |=> RESULT[31:24] == $past(chk_b3)) else $error("top byte lane sum wrong");
   a_doubleword_address_add_linear: assert property (CE && exec && OP == OP_DWADR_ADD && !circ_reg // RL9
      |=> RESULT == $past(chk_lin)) else $error("linear doubleword add wrong");
   a_circ_upper_kept: assert property (CE && exec && OP == OP_DWADR_ADD && circ // RL15
      |=> ((RESULT ^ $past(SRC2)) & ~$past(circ_mask)) == 32'h0) else $error("circular add changed upper bits");
   a_pcrel_value: assert property (CE && exec && OP == OP_PCREL_ADD && CONST7 == 7'h7f // RL11
      |=> RESULT == $past(FETCH_BASE) - 32'h4) else $error("pc-relative add wrong");
   // The three busy cycles are the ones the enable run covers; the next cycle must be free again.
   a_nop_three: assert property (CE && accept && legal && OP == OP_PCREL_ADD && NOP_COUNT == 3'h3 // RL12
      ##1 CE [*3] |-> $past(BUSY, 2) && $past(BUSY) && BUSY ##1 !BUSY)
      else $error("three nop cycles not inserted");
   a_pred_fail_hold: assert property (CE && accept && !COND_PASS // RL17
      |=> !RESULT_WE && $stable(RESULT)) else $error("failed predicate wrote result");
   a_zero_delay: assert property (CE && exec |=> RESULT_WE) // RL18
      else $error("result not visible next cycle");

   c_abs_saturate: cover property (CE && exec && OP == OP_HALF_ABS && SRC2[15:0] == 16'h8000);
   c_circ_wrap: cover property (CE && exec && OP == OP_DWADR_ADD && circ && adr_val != lin_val);
   c_nop_insert: cover property (CE && accept && OP == OP_PCREL_ADD && NOP_COUNT == 3'h7);
   c_pred_fail: cover property (CE && accept && legal && !COND_PASS);

endmodule // psa_unit
`default_nettype wire

// >>> common/psa_regs.svh
// Named constants for the packed add and absolute-value datapath.
`ifndef PSA_REGS_SVH
`define PSA_REGS_SVH
`define PSA_HALF_W        16
`define PSA_BYTE_W        8
`define PSA_HALF_MIN      16'h8000
`define PSA_HALF_MAX      16'h7fff
`define PSA_HALF_ONE      16'h0001
`define PSA_DW_SHIFT      3
`define PSA_PCREL_SHIFT   2
`define PSA_AMR_BK0_LSB   16
`define PSA_AMR_BK1_LSB   21
`define PSA_BK_W          5
`define PSA_MODE_W        2
`define PSA_MODE_CIRC0    2'h1
`define PSA_MODE_CIRC1    2'h2
`define PSA_CIRC_IDX_LO   5'h04
`define PSA_CIRC_IDX_HI   5'h07
`define PSA_ONES64        64'hffff_ffff_ffff_ffff
`define PSA_SHAMT_ONE     6'h01
`define PSA_ZERO32        32'h0000_0000
`define PSA_NOP_ZERO      3'h0
`define PSA_NOP_ONE       3'h1
`endif

// >>> common/psa_pkg.sv
// Types shared by the packed add and absolute-value datapath.
package psa_pkg;
   typedef enum logic [4:0] {
      OP_HALF_ABS  = 5'h01,
      OP_HALF_ADD  = 5'h02,
      OP_BYTE_ADD  = 5'h04,
      OP_DWADR_ADD = 5'h08,
      OP_PCREL_ADD = 5'h10
   } psa_op_type;

   typedef enum logic [2:0] {
      UNIT_SHIFT = 3'h1,
      UNIT_LOGIC = 3'h2,
      UNIT_DADDR = 3'h4
   } psa_unit_type;

   typedef enum logic [1:0] {
      ST_RUN = 2'h1,
      ST_NOP = 2'h2
   } psa_state_type;
endpackage

// >>> hdl/psa_lane_add.sv
// One carry-isolated lane adder; the sum wraps modulo two to the lane width.
`timescale 1ns/1ps
`default_nettype none
module psa_lane_add #(
   parameter int W = 8
) (
   input  wire logic [W-1:0] a,
   input  wire logic [W-1:0] b,
   output logic      [W-1:0] sum
);
   assign sum = a + b;
endmodule // psa_lane_add
`default_nettype wire

// >>> sim/psa_dst_model.sv
// Destination register file side: keeps the last value the datapath writes back and counts the writes.
`timescale 1ns/1ps
`default_nettype none
module psa_dst_model (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic [31:0] result,
   input  wire logic        result_we,
   output logic      [31:0] dst_ff,
   output logic      [15:0] writes_ff
);
   logic [31:0] nxt_dst;
   logic [15:0] nxt_writes;
   always_comb begin
      nxt_dst    = dst_ff;
      nxt_writes = writes_ff;
      if (result_we) begin
         nxt_dst    = result;
         nxt_writes = writes_ff + 16'h0001;
      end
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         dst_ff    <= 32'h0000_0000;
         writes_ff <= 16'h0000;
      end else begin
         dst_ff    <= nxt_dst;
         writes_ff <= nxt_writes;
      end
   end
endmodule // psa_dst_model
`default_nettype wire

// >>> sim/testbench.sv
// Self-checking bench for the packed add and absolute-value datapath.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin n_fail++; \
   $display("mismatch %s exp %h got %h", nm, ex, got); end end
module testbench;
   import psa_pkg::*;
   logic CLK, NRST, CE, ISSUE, COND_PASS, BASE_SIDE_B, RESULT_WE, BUSY, ILLEGAL, SAT_SET;
   psa_op_type   OP;
   psa_unit_type UNIT;
   logic [31:0]  SRC1, SRC2, ADDRESSING_MODE_REGISTER, FETCH_BASE, RESULT, dst, exp_res;
   logic [4:0]   BASE_IDX;
   logic [6:0]   CONST7;
   logic [2:0]   NOP_COUNT;
   logic [15:0]  writes;
   int           n_fail, comparisons, n_wr;
   psa_op_type   ops [5] = '{OP_HALF_ABS, OP_HALF_ADD, OP_BYTE_ADD, OP_DWADR_ADD, OP_PCREL_ADD};
   psa_unit_type units [3] = '{UNIT_SHIFT, UNIT_LOGIC, UNIT_DADDR};

   psa_unit u_dut (.CLK(CLK), .NRST(NRST), .CE(CE), .ISSUE(ISSUE), .OP(OP), .UNIT(UNIT),
      .COND_PASS(COND_PASS), .SRC1(SRC1), .SRC2(SRC2), .BASE_IDX(BASE_IDX), .BASE_SIDE_B(BASE_SIDE_B),
      .ADDRESSING_MODE_REGISTER(ADDRESSING_MODE_REGISTER), .FETCH_BASE(FETCH_BASE), .CONST7(CONST7), .NOP_COUNT(NOP_COUNT), .RESULT(RESULT),
      .RESULT_WE(RESULT_WE), .BUSY(BUSY), .ILLEGAL(ILLEGAL), .SAT_SET(SAT_SET));
   psa_dst_model u_dst (.clk(CLK), .nrst(NRST), .result(RESULT), .result_we(RESULT_WE),
      .dst_ff(dst), .writes_ff(writes));

   initial begin
      CLK = 1'b0;
      forever #20 CLK = ~CLK;
   end

   function automatic logic legal(psa_op_type o, psa_unit_type u);
      case (o)
         OP_HALF_ABS, OP_BYTE_ADD: return u == UNIT_LOGIC;
         OP_DWADR_ADD:             return u == UNIT_DADDR;
         OP_PCREL_ADD:             return u == UNIT_SHIFT;
         default:                  return 1'b1;
      endcase
   endfunction

   function automatic logic [31:0] model(psa_op_type o);
      longint s, m;
      int v, n, md;
      logic [31:0] r;
      r = '0;
      for (int i = 0; i < 4; i++) begin
         if (o == OP_BYTE_ADD) r[8*i +: 8] = (SRC1[8*i +: 8] + SRC2[8*i +: 8]) % 256;
         if (o == OP_HALF_ADD && i < 2) r[16*i +: 16] = SRC1[16*i +: 16] + SRC2[16*i +: 16];
         if (o == OP_HALF_ABS && i < 2) begin
            v = int'($signed(SRC2[16*i +: 16]));
            r[16*i +: 16] = (v == -32768) ? 32767 : (v < 0 ? -v : v);
         end
      end
      if (o == OP_PCREL_ADD) r = FETCH_BASE + 4 * int'($signed(CONST7));
      if (o == OP_DWADR_ADD) begin
         s = longint'(SRC2) + 8 * longint'(SRC1);
         md = (BASE_IDX >= 4 && BASE_IDX <= 7) ? ADDRESSING_MODE_REGISTER[8 * BASE_SIDE_B + 2 * (BASE_IDX - 4) +: 2] : 0;
         n = (md == 1) ? ADDRESSING_MODE_REGISTER[20:16] : ADDRESSING_MODE_REGISTER[25:21];
         m = (longint'(1) << (n + 1)) - 1;
         r = (md == 1 || md == 2) ? ((SRC2 & ~m) | (s & m)) : s;
      end
      return r;
   endfunction

   // Called at a falling edge; the op is taken at the next rising edge.
   // The issue strobe is left high so that back-to-back calls never toggle it within one step.
   // The destination file lags the result by one edge, so it must still hold the previous write.
   task automatic run(psa_op_type o, psa_unit_type u, logic c);
      logic [31:0] prev_res;
      prev_res = exp_res;
      OP = o;
      UNIT = u;
      COND_PASS = c;
      ISSUE = 1'b1;
      @(negedge CLK);
      if (legal(o, u) && c) begin
         exp_res = model(o);
         n_wr++;
      end
      `CHK("illegal", !legal(o, u), ILLEGAL)
      `CHK("we", legal(o, u) && c, RESULT_WE)
      `CHK("result", exp_res, RESULT)
      `CHK("dst", prev_res, dst)
      `CHK("sat", 1'b0, SAT_SET)
   endtask

   task automatic close_out();
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial begin
      #(40 * 3000);
      n_fail++;
      close_out();
   end

   initial begin
      {NRST, ISSUE, COND_PASS, BASE_SIDE_B, SRC1, SRC2, ADDRESSING_MODE_REGISTER, FETCH_BASE, BASE_IDX, CONST7, NOP_COUNT} = '0;
      CE = 1'b1;
      OP = OP_HALF_ADD;
      UNIT = UNIT_SHIFT;
      exp_res = '0;
      void'($urandom(32'h4a2c));
      repeat (5) @(negedge CLK);
      NRST = 1'b1;
      `CHK("rst", 4'h0, {RESULT_WE, BUSY, ILLEGAL, RESULT[0]})
      for (int k = 0; k < 300; k++) begin
         {SRC1, SRC2, ADDRESSING_MODE_REGISTER, FETCH_BASE} = {$urandom, (k % 7 == 0) ? 32'h8000_ff68 : $urandom, $urandom, $urandom};
         BASE_IDX = 5'($urandom % 10);
         BASE_SIDE_B = 1'($urandom);
         CONST7 = 7'($urandom);
         run(ops[$urandom % 5], units[$urandom % 3], ($urandom % 4) != 0);
      end
      SRC2 = 32'h8000_8000;
      run(OP_HALF_ABS, UNIT_LOGIC, 1'b1);
      CONST7 = 7'h7f;
      run(OP_PCREL_ADD, UNIT_SHIFT, 1'b1);
      run(OP_HALF_ADD, UNIT_LOGIC, 1'b0);
      // With the enable low an executable issue must leave the result and its write strobe frozen.
      CE = 1'b0;
      COND_PASS = 1'b1;
      @(negedge CLK);
      `CHK("ce hold we", 1'b0, RESULT_WE)
      `CHK("ce hold", exp_res, RESULT)
      CE = 1'b1;
      for (int k = 0; k < 8; k++) begin
         NOP_COUNT = 3'(k);
         run(OP_PCREL_ADD, UNIT_SHIFT, k[0]);
         `CHK("busy", k != 0, BUSY)
         // The issue at the edge that ends the last busy cycle is still refused.
         for (int i = 1; i <= k; i++) begin
            OP = OP_HALF_ADD;
            ISSUE = 1'b1;
            @(negedge CLK);
            `CHK("busy", i < k, BUSY)
            `CHK("we", 1'b0, RESULT_WE)
         end
         NOP_COUNT = 3'h0;
         run(OP_HALF_ADD, UNIT_DADDR, 1'b1);
         `CHK("busy", 1'b0, BUSY)
      end
      ISSUE = 1'b0;
      @(negedge CLK);
      `CHK("dst", exp_res, dst)
      `CHK("writes", 16'(n_wr), writes)
      close_out();
   end
endmodule // testbench
`default_nettype wire
